// ---- ulmc_uart.sv ----
// Purpose: line/modem control, status, address match and baud divisor
// Assumes: one clock, one-byte tx holding and rx buffer
// Notes: baud tick from prescaler on doubled clock, then 16-bit divisor
`timescale 1ns/1ps
module ulmc_uart (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_rxd,
   input wire logic i_cts_n,
   input wire logic i_dsr_n,
   input wire logic i_ri_n,
   input wire logic i_dcd_n,
   output logic o_txd,
   output logic o_rts_n,
   output logic o_dtr_n,
   output logic o_irq
);
   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] lcr;
      logic [7:0] mcr;
      logic [7:0] ier;
      logic [7:0] laddr;
      logic [7:0] divlo;
      logic [7:0] divhi;
      logic [7:0] pre;
      logic [7:0] pre_cnt;
      logic [15:0] div_cnt;
      logic [1:0] rx_s;
      logic [3:0] modem_s1;
      logic [3:0] modem_s2;
      logic [3:0] modem_s3;
      logic [3:0] modem_delta;
      logic [7:0] thr;
      logic thr_full;
      ulmc_pkg::ulmc_ser_type tx_st;
      logic [3:0] tx_ovs;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic tx_stop2;
      logic txd;
      ulmc_pkg::ulmc_ser_type rx_st;
      logic [3:0] rx_ovs;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_par;
      logic [7:0] rbr;
      logic rdy;
      logic [3:0] errs;
      logic err_sum;
      logic addr_open;
      logic addr_hit;
   } ulmc_state_type;
   ulmc_state_type s_reg;
   ulmc_state_type s_next;
   logic tick;
   logic rx_line;
   logic [2:0] nbits;
   logic tx_par;
   logic match_on;
   logic rx_busy;
   logic hit_set;
   function automatic logic par_of(input logic [7:0] d, input logic [7:0] lcr,
                                   input logic [2:0] nb);
      logic [7:0] m;
      m = 8'hff >> (3'h7 - nb);
      unique case (lcr[ulmc_pkg::LC_PAR_HI:ulmc_pkg::LC_PAR_LO])
         2'b00: par_of = ~^(d & m);
         2'b01: par_of = ^(d & m);
         2'b10: par_of = 1'b1;
         2'b11: par_of = 1'b0;
      endcase
   endfunction : par_of
   // ----------------------------------------
   // combinational datapath
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      hit_set = 1'b0;
      nbits = 3'h4 + {1'b0, s_reg.lcr[1:0]};
      match_on = (s_reg.laddr != ulmc_pkg::ADDR_NONE) && s_reg.lcr[ulmc_pkg::LC_PAR_ON];
      rx_busy = (s_reg.rx_st != ulmc_pkg::ULMC_IDLE);
      tx_par = par_of(s_reg.tx_sh, s_reg.lcr, nbits);
      // baud: prescaler counts two per clock, modelling the doubled clock
      tick = 1'b0;
      if (s_reg.pre_cnt + 8'h02 >= s_reg.pre) begin
         s_next.pre_cnt = 8'h00;
         if (s_reg.div_cnt + 16'h0001 >= {s_reg.divhi, s_reg.divlo}) begin
            s_next.div_cnt = 16'h0000;
            tick = 1'b1;
         end else begin
            s_next.div_cnt = s_reg.div_cnt + 16'h0001;
         end
      end else begin
         s_next.pre_cnt = s_reg.pre_cnt + 8'h02;
      end
      // synchronisers
      s_next.rx_s = {s_reg.rx_s[0], i_rxd};
      s_next.modem_s1 = ~{i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
      s_next.modem_s2 = s_reg.modem_s1;
      // edges taken past the second stage only, never from the metastable one
      s_next.modem_s3 = s_reg.modem_s2;
      s_next.modem_delta = s_reg.modem_delta | (s_reg.modem_s2 ^ s_reg.modem_s3);
      rx_line = s_reg.mcr[ulmc_pkg::MC_LOOP] ? s_reg.txd : s_reg.rx_s[1];
      // ----- register reads, clear-on-read before new sets so sets win
      s_next.rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            ulmc_pkg::ADDR_DATA: begin
               s_next.rdata = s_reg.lcr[ulmc_pkg::LC_DLAB] ? s_reg.divlo : s_reg.rbr;
               if (!s_reg.lcr[ulmc_pkg::LC_DLAB]) begin
                  s_next.rdy = 1'b0;
               end
            end
            ulmc_pkg::ADDR_DIVHI_IE:
               s_next.rdata = s_reg.lcr[ulmc_pkg::LC_DLAB] ? s_reg.divhi : s_reg.ier;
            ulmc_pkg::ADDR_LINE_CTL: s_next.rdata = s_reg.lcr;
            ulmc_pkg::ADDR_MODEM_CTL: s_next.rdata = s_reg.mcr;
            ulmc_pkg::ADDR_LINE_STAT: begin
               s_next.rdata = {s_reg.err_sum, ~s_reg.thr_full & (s_reg.tx_st == ulmc_pkg::ULMC_IDLE),
                               ~s_reg.thr_full, s_reg.errs, s_reg.rdy};
               s_next.errs = 4'h0;
               s_next.err_sum = 1'b0;
            end
            ulmc_pkg::ADDR_MODEM_STAT: begin
               s_next.rdata = {s_reg.modem_s2, s_reg.modem_delta};
               s_next.modem_delta = s_reg.modem_s2 ^ s_reg.modem_s3;
            end
            ulmc_pkg::ADDR_PRE_LADDR:
               s_next.rdata = s_reg.lcr[ulmc_pkg::LC_DLAB] ? s_reg.pre : s_reg.laddr;
            default: s_next.rdata = 8'h00;
         endcase
      end
      // ----- register writes
      if (i_wr) begin
         unique case (i_addr)
            ulmc_pkg::ADDR_DATA:
               if (s_reg.lcr[ulmc_pkg::LC_DLAB]) begin
                  s_next.divlo = i_wdata;
               end else begin
                  s_next.thr = i_wdata;
                  s_next.thr_full = 1'b1;
               end
            ulmc_pkg::ADDR_DIVHI_IE:
               if (s_reg.lcr[ulmc_pkg::LC_DLAB]) begin
                  s_next.divhi = i_wdata;
               end else begin
                  s_next.ier = i_wdata;
               end
            ulmc_pkg::ADDR_LINE_CTL: s_next.lcr = i_wdata;
            ulmc_pkg::ADDR_MODEM_CTL: s_next.mcr = i_wdata;
            ulmc_pkg::ADDR_PRE_LADDR:
               if (s_reg.lcr[ulmc_pkg::LC_DLAB]) begin
                  s_next.pre = i_wdata;
               end else begin
                  s_next.laddr = i_wdata;
                  s_next.addr_open = 1'b0;
               end
            default: ;
         endcase
      end
      // ----------------------------------------
      // transmitter
      // ----------------------------------------
      if (tick) begin
         unique case (s_reg.tx_st)
            ulmc_pkg::ULMC_IDLE: begin
               s_next.txd = ~s_reg.lcr[ulmc_pkg::LC_BREAK];
               if (s_reg.thr_full && (!s_reg.mcr[ulmc_pkg::MC_AUTO] || s_reg.modem_s2[0])
                   && !(s_reg.mcr[ulmc_pkg::MC_HALF] && rx_busy)) begin
                  s_next.tx_st = ulmc_pkg::ULMC_START;
                  s_next.tx_sh = s_reg.thr;
                  s_next.thr_full = i_wr && (i_addr == ulmc_pkg::ADDR_DATA)
                                    && !s_reg.lcr[ulmc_pkg::LC_DLAB];
                  s_next.tx_ovs = 4'h0;
                  s_next.tx_bit = 3'h0;
                  s_next.addr_open = 1'b0;
                  s_next.txd = 1'b0;
               end
            end
            ulmc_pkg::ULMC_START, ulmc_pkg::ULMC_DATA, ulmc_pkg::ULMC_PAR,
            ulmc_pkg::ULMC_STOP: begin
               s_next.tx_ovs = s_reg.tx_ovs + 4'h1;
               if (s_reg.tx_ovs == ulmc_pkg::OVS_LAST) begin
                  if (s_reg.tx_st == ulmc_pkg::ULMC_START) begin
                     s_next.tx_st = ulmc_pkg::ULMC_DATA;
                     s_next.txd = s_reg.tx_sh[0];
                  end else if (s_reg.tx_st == ulmc_pkg::ULMC_DATA) begin
                     s_next.tx_bit = s_reg.tx_bit + 3'h1;
                     s_next.txd = s_reg.tx_sh[s_reg.tx_bit + 3'h1];
                     if (s_reg.tx_bit == nbits) begin
                        if (s_reg.lcr[ulmc_pkg::LC_PAR_ON]) begin
                           s_next.tx_st = ulmc_pkg::ULMC_PAR;
                           // holding register may already carry the next byte
                           s_next.txd = tx_par;
                        end else begin
                           s_next.tx_st = ulmc_pkg::ULMC_STOP;
                           s_next.txd = 1'b1;
                           s_next.tx_stop2 = s_reg.lcr[ulmc_pkg::LC_STOP2];
                        end
                     end
                  end else if (s_reg.tx_st == ulmc_pkg::ULMC_PAR) begin
                     s_next.tx_st = ulmc_pkg::ULMC_STOP;
                     s_next.txd = 1'b1;
                     s_next.tx_stop2 = s_reg.lcr[ulmc_pkg::LC_STOP2];
                  end else if (s_reg.tx_stop2) begin
                     s_next.tx_stop2 = 1'b0;
                  end else begin
                     s_next.tx_st = ulmc_pkg::ULMC_IDLE;
                  end
               end
            end
            default: s_next.tx_st = ulmc_pkg::ULMC_IDLE;
         endcase
      end
      // ----------------------------------------
      // receiver, sampled mid-bit at 16x
      // ----------------------------------------
      if (tick) begin
         unique case (s_reg.rx_st)
            ulmc_pkg::ULMC_IDLE:
               // half duplex: ignore the line while our own frame is out
               if (!rx_line && !(s_reg.mcr[ulmc_pkg::MC_HALF]
                   && s_reg.tx_st != ulmc_pkg::ULMC_IDLE)) begin
                  s_next.rx_st = ulmc_pkg::ULMC_START;
                  s_next.rx_ovs = 4'h0;
                  s_next.rx_bit = 3'h0;
                  s_next.rx_sh = 8'h00;
               end
            ulmc_pkg::ULMC_START: begin
               s_next.rx_ovs = s_reg.rx_ovs + 4'h1;
               if (s_reg.rx_ovs == ulmc_pkg::OVS_MID) begin
                  s_next.rx_ovs = 4'h0;
                  s_next.rx_st = rx_line ? ulmc_pkg::ULMC_IDLE : ulmc_pkg::ULMC_DATA;
               end
            end
            ulmc_pkg::ULMC_DATA, ulmc_pkg::ULMC_PAR, ulmc_pkg::ULMC_STOP: begin
               s_next.rx_ovs = s_reg.rx_ovs + 4'h1;
               if (s_reg.rx_ovs == ulmc_pkg::OVS_LAST) begin
                  if (s_reg.rx_st == ulmc_pkg::ULMC_DATA) begin
                     s_next.rx_sh[s_reg.rx_bit] = rx_line;
                     s_next.rx_bit = s_reg.rx_bit + 3'h1;
                     if (s_reg.rx_bit == nbits) begin
                        s_next.rx_st = s_reg.lcr[ulmc_pkg::LC_PAR_ON] ? ulmc_pkg::ULMC_PAR
                                                                       : ulmc_pkg::ULMC_STOP;
                     end
                  end else if (s_reg.rx_st == ulmc_pkg::ULMC_PAR) begin
                     s_next.rx_par = rx_line;
                     s_next.rx_st = ulmc_pkg::ULMC_STOP;
                  end else begin
                     s_next.rx_st = ulmc_pkg::ULMC_IDLE;
                     // address frame: ninth bit one under mark-style setup
                     if (match_on && s_reg.rx_par) begin
                        if (s_reg.rx_sh == s_reg.laddr || s_reg.rx_sh == ulmc_pkg::ADDR_BCAST) begin
                           s_next.addr_open = 1'b1;
                           s_next.addr_hit = 1'b1;
                           hit_set = 1'b1;
                        end else begin
                           s_next.addr_open = 1'b0;
                        end
                     end else if (!match_on || s_reg.addr_open) begin
                        s_next.rbr = s_reg.rx_sh;
                        s_next.rdy = 1'b1;
                        if (s_reg.rdy) begin
                           s_next.errs[0] = 1'b1;
                        end
                        if (!rx_line) begin
                           s_next.errs[2] = 1'b1;
                           if (s_reg.rx_sh == 8'h00) begin
                              s_next.errs[3] = 1'b1;
                           end
                        end
                        if (s_reg.lcr[ulmc_pkg::LC_PAR_ON] &&
                            (s_reg.rx_par != par_of(s_reg.rx_sh, s_reg.lcr, nbits))) begin
                           s_next.errs[1] = 1'b1;
                        end
                     end
                  end
               end
            end
            default: s_next.rx_st = ulmc_pkg::ULMC_IDLE;
         endcase
      end
      s_next.err_sum = s_next.err_sum | (|(s_next.errs & ~s_reg.errs));
      if (!match_on) begin
         s_next.addr_hit = 1'b0;
      end else if (i_rd && i_addr == ulmc_pkg::ADDR_LINE_STAT && !hit_set) begin
         s_next.addr_hit = 1'b0;
      end
   end
   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s_reg <= '0;
         s_reg.laddr <= ulmc_pkg::RST_LADDR;
         s_reg.divhi <= ulmc_pkg::RST_DIVHI;
         s_reg.divlo <= ulmc_pkg::RST_DIVLO;
         s_reg.pre <= ulmc_pkg::RST_PRE;
         s_reg.rx_s <= 2'b11;
         s_reg.modem_s1 <= 4'hf;
         s_reg.modem_s2 <= 4'hf;
         s_reg.modem_s3 <= 4'hf;
         s_reg.txd <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_comb begin
      o_rdata = s_reg.rdata;
      o_txd = s_reg.txd;
      o_dtr_n = ~s_reg.mcr[ulmc_pkg::MC_DTR];
      if (!s_reg.mcr[ulmc_pkg::MC_RTSFN]) begin
         o_rts_n = ~(s_reg.tx_st != ulmc_pkg::ULMC_IDLE);
      end else if (s_reg.mcr[ulmc_pkg::MC_AUTO]) begin
         o_rts_n = s_reg.rdy;
      end else begin
         o_rts_n = ~s_reg.mcr[ulmc_pkg::MC_RTS];
      end
      o_irq = s_reg.mcr[ulmc_pkg::MC_GATE] &
              ((s_reg.ier[0] & s_reg.rdy) | (s_reg.ier[1] & ~s_reg.thr_full) |
               (s_reg.ier[2] & s_reg.err_sum) | (s_reg.ier[3] & |s_reg.modem_delta) |
               s_reg.addr_hit);
   end
endmodule : ulmc_uart

// ---- ulmc_pkg.sv ----
// Purpose: shared constants for the uart line/modem control block
// Assumes: byte registers on a plain strobe port, 100 MHz system clock
// Notes: offsets are register indices on the local port
package ulmc_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [3:0] ADDR_DATA = 4'h0;
   localparam logic [3:0] ADDR_DIVHI_IE = 4'h1;
   localparam logic [3:0] ADDR_LINE_CTL = 4'h3;
   localparam logic [3:0] ADDR_MODEM_CTL = 4'h4;
   localparam logic [3:0] ADDR_LINE_STAT = 4'h5;
   localparam logic [3:0] ADDR_MODEM_STAT = 4'h6;
   localparam logic [3:0] ADDR_PRE_LADDR = 4'h7;
   localparam logic [3:0] ADDR_DIVLO = 4'h2;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int LC_DLAB = 7;
   localparam int LC_BREAK = 6;
   localparam int LC_PAR_HI = 5;
   localparam int LC_PAR_LO = 4;
   localparam int LC_PAR_ON = 3;
   localparam int LC_STOP2 = 2;
   localparam int MC_HALF = 7;
   localparam int MC_RTSFN = 6;
   localparam int MC_AUTO = 5;
   localparam int MC_LOOP = 4;
   localparam int MC_GATE = 3;
   localparam int MC_RTS = 1;
   localparam int MC_DTR = 0;
   // ----------------------------------------
   // reset values, match addresses and oversampling points
   // ----------------------------------------
   localparam logic [7:0] RST_LADDR = 8'hff;
   localparam logic [7:0] RST_DIVHI = 8'h80;
   localparam logic [7:0] RST_DIVLO = 8'h01;
   localparam logic [7:0] RST_PRE = 8'h01;
   localparam logic [7:0] ADDR_NONE = 8'hff;
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [3:0] OVS_LAST = 4'hf;
   localparam logic [3:0] OVS_MID = 4'h7;
   typedef enum logic [2:0] {
      ULMC_IDLE = 3'b000,
      ULMC_START = 3'b001,
      ULMC_DATA = 3'b011,
      ULMC_PAR = 3'b010,
      ULMC_STOP = 3'b110
   } ulmc_ser_type;
endpackage : ulmc_pkg

// ---- ulmc_uart_chk_sva.sv ----
// Purpose: port-level assertions for the uart line/modem control block
// Assumes: one clock domain, reset asynchronous and active high
// Notes: modem control is shadowed from the register port
`timescale 1ns/1ps
module ulmc_uart_chk (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_rxd,
   input wire logic i_cts_n,
   input wire logic i_dsr_n,
   input wire logic i_ri_n,
   input wire logic i_dcd_n,
   input wire logic o_txd,
   input wire logic o_rts_n,
   input wire logic o_dtr_n,
   input wire logic o_irq
);
   // ----------------------------------------
   // helper state
   // ----------------------------------------
   logic [7:0] mcr_reg;
   logic [1:0] age_reg;
   logic [3:0] quiet_reg;
   logic [3:0] prev_reg;
   logic mread_reg;
   logic [3:0] modem_n;
   logic mcr_wr;
   logic msr_rd;
   logic msr_again;
   assign modem_n = {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
   assign mcr_wr = i_wr && (i_addr == ulmc_pkg::ADDR_MODEM_CTL);
   assign msr_rd = i_rd && (i_addr == ulmc_pkg::ADDR_MODEM_STAT);
   assign msr_again = msr_rd && mread_reg;
   // quiet hides the synchroniser lag of the modem pins
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mcr_reg <= 8'h00;
         age_reg <= 2'h0;
         quiet_reg <= 4'h0;
         prev_reg <= 4'h0;
         mread_reg <= 1'b0;
      end else begin
         mcr_reg <= mcr_wr ? i_wdata : mcr_reg;
         age_reg <= mcr_wr ? 2'h0 : (age_reg[1] ? 2'h2 : age_reg + 2'h1);
         prev_reg <= modem_n;
         if (modem_n != prev_reg) begin
            quiet_reg <= 4'h0;
            mread_reg <= 1'b0;
         end else begin
            quiet_reg <= (quiet_reg == 4'hf) ? quiet_reg : quiet_reg + 4'h1;
            mread_reg <= mread_reg || (msr_rd && quiet_reg[3]);
         end
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   reset_idle_a: assert property ($fell(i_sys_rst) |-> o_txd && o_rts_n && o_dtr_n && !o_irq)
      else $error("outputs not idle after reset");
   read_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside its cycle");
   dtr_level_a: assert property (age_reg[1] && !mcr_reg[4] |-> o_dtr_n == !mcr_reg[0])
      else $error("dtr pin differs from control bit");
   rts_level_a: assert property (age_reg[1] && mcr_reg[6:4] == 3'b100 |-> o_rts_n == !mcr_reg[1])
      else $error("rts pin differs from control bit");
   tx_in_progress_out_busy_a: assert property (age_reg[1] && mcr_reg[6:4] == 3'b000
      && !o_txd && !$past(o_txd) |-> !o_rts_n)
      else $error("no transmit indication during frame");
   irq_gate_a: assert property (age_reg[1] && !mcr_reg[3] |-> !o_irq)
      else $error("interrupt passed a closed gate");
   modem_state_a: assert property ($past(msr_rd) && quiet_reg[3] && !mcr_reg[4]
      |-> o_rdata[7:4] == ~modem_n)
      else $error("modem state bits wrong");
   modem_clear_a: assert property ($past(msr_again) |-> o_rdata[3:0] == 4'h0)
      else $error("modem change flags not cleared by read");
   cover property (msr_again);
   cover property ($fell(o_txd));
   cover property (mcr_reg[3] && o_irq);
endmodule : ulmc_uart_chk
bind ulmc_uart ulmc_uart_chk u_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_rxd(i_rxd), .i_cts_n(i_cts_n), .i_dsr_n(i_dsr_n), .i_ri_n(i_ri_n), .i_dcd_n(i_dcd_n),
   .o_txd(o_txd), .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n), .o_irq(o_irq));

// ---- ulmc_far_end.sv ----
// Purpose: remote station on the serial line
// Assumes: sixteen clocks per bit
// Notes: line idles high; spare captured bits therefore read one
`timescale 1ns/1ps
module ulmc_far_end (
   input wire logic i_ref_clk,
   input wire logic i_txd,
   output logic o_rxd
);
   initial o_rxd = 1'b1;
   task automatic send_frame(input logic [11:0] bits, input int nb);
      o_rxd <= 1'b0;
      repeat (16) @(posedge i_ref_clk);
      for (int i = 0; i < nb; i++) begin
         o_rxd <= bits[i];
         repeat (16) @(posedge i_ref_clk);
      end
      o_rxd <= 1'b1;
   endtask : send_frame
   // samples mid-bit; a late start costs margin, not a wrong bit
   task automatic catch_frame(output logic [11:0] bits);
      int n;
      n = 0;
      bits = 12'hfff;
      while (i_txd && n < 2000) begin
         @(posedge i_ref_clk);
         n++;
      end
      repeat (8) @(posedge i_ref_clk);
      for (int i = 0; i < 12; i++) begin
         repeat (16) @(posedge i_ref_clk);
         bits[i] = i_txd;
      end
   endtask : catch_frame
endmodule : ulmc_far_end

// ---- tb_top.sv ----
// Purpose: self-checking bench for the uart line/modem control block
// Assumes: prescaler 2 and divisor 1 give sixteen clocks per bit
// Notes: register port driven by tasks, serial side by the far end
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
   $display("mismatch at %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] modem_n = 4'h0;
   logic [7:0] rdata;
   logic rxd;
   logic txd;
   logic rts_n;
   logic dtr_n;
   logic irq;
   logic [11:0] bits;
   logic [7:0] lcr_t [5] = '{8'h03, 8'h08, 8'h19, 8'h2a, 8'h3f};
   logic [7:0] dat_t [5] = '{8'ha5, 8'h13, 8'h2c, 8'h5e, 8'hc3};
   int checks = 0;
   int fails = 0;
   always #5 ref_clk = ~ref_clk;
   ulmc_uart u_dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rxd(rxd),
      .i_cts_n(modem_n[0]), .i_dsr_n(modem_n[1]), .i_ri_n(modem_n[2]),
      .i_dcd_n(modem_n[3]), .o_txd(txd), .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_irq(irq));
   ulmc_far_end u_far (.i_ref_clk(ref_clk), .i_txd(txd), .o_rxd(rxd));
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : rd_chk
   // data lsb first, then parity if on; stop and idle bits stay one
   function automatic logic [11:0] frame_bits(input logic [7:0] lcr, input logic [7:0] d);
      int nb;
      logic x;
      frame_bits = 12'hfff;
      nb = 5 + int'(lcr[1:0]);
      x = 1'b0;
      for (int i = 0; i < nb; i++) begin
         frame_bits[i] = d[i];
         x ^= d[i];
      end
      if (lcr[3]) begin
         frame_bits[nb] = (lcr[5:4] == 2'b00) ? ~x : (lcr[5:4] == 2'b01) ? x : ~lcr[4];
      end
   endfunction : frame_bits
   task automatic rx_send(input logic [7:0] lcr, input logic [7:0] d, input logic [11:0] flip);
      u_far.send_frame(frame_bits(lcr, d) ^ flip, 6 + int'(lcr[1:0]) + int'(lcr[3]));
      repeat (8) @(posedge ref_clk);
   endtask : rx_send
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #200000;
      fails++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd_chk(4'h5, 8'h60);
      rd_chk(4'h6, 8'hf0);
      rd_chk(4'h7, 8'hff);
      rd_chk(4'hf, 8'h00);
      wr_reg(4'h3, 8'h80);
      rd_chk(4'h1, 8'h80);
      wr_reg(4'h7, 8'h02);
      wr_reg(4'h1, 8'h00);
      wr_reg(4'h0, 8'h01);
      rd_chk(4'h7, 8'h02);
      rd_chk(4'h1, 8'h00);
      rd_chk(4'h0, 8'h01);
      wr_reg(4'h3, 8'h00);
      rd_chk(4'h7, 8'hff);
      $display("test reset and divisor done");
      wr_reg(4'h4, 8'h43);
      rd_chk(4'h4, 8'h43);
      `CHK({rts_n, dtr_n}, 2'b00)
      wr_reg(4'h4, 8'h40);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK({rts_n, dtr_n}, 2'b11)
      for (int k = 0; k < 4; k++) begin
         @(posedge ref_clk);
         modem_n[k] <= ~modem_n[k];
         repeat (10) @(posedge ref_clk);
         rd_chk(4'h6, {~modem_n, 4'(1 << k)});
         rd_chk(4'h6, {~modem_n, 4'h0});
      end
      $display("test modem pins done");
      wr_reg(4'h4, 8'h00);
      for (int t = 0; t < 5; t++) begin
         wr_reg(4'h3, lcr_t[t]);
         wr_reg(4'h0, dat_t[t]);
         u_far.catch_frame(bits);
         `CHK(bits, frame_bits(lcr_t[t], dat_t[t]))
      end
      repeat (20) @(posedge ref_clk);
      rd_chk(4'h5, 8'h60);
      wr_reg(4'h4, 8'h60);
      wr_reg(4'h0, 8'h96);
      repeat (100) @(posedge ref_clk);
      rd_chk(4'h5, 8'h00);
      `CHK(rts_n, 1'b0)
      @(posedge ref_clk);
      modem_n[0] <= 1'b0;
      u_far.catch_frame(bits);
      `CHK(bits, frame_bits(lcr_t[4], 8'h96))
      wr_reg(4'h4, 8'h00);
      $display("test transmit formats done");
      wr_reg(4'h3, 8'h1b);
      rx_send(8'h1b, 8'h3c, 12'h000);
      rd_chk(4'h5, 8'h61);
      rd_chk(4'h0, 8'h3c);
      rd_chk(4'h5, 8'h60);
      rx_send(8'h1b, 8'h3d, 12'h100);
      rd_chk(4'h5, 8'he5);
      rd_chk(4'h5, 8'h61);
      rd_chk(4'h0, 8'h3d);
      rx_send(8'h1b, 8'h42, 12'h200);
      rd_chk(4'h5, 8'he9);
      rd_chk(4'h0, 8'h42);
      rx_send(8'h1b, 8'h11, 12'h000);
      rx_send(8'h1b, 8'h22, 12'h000);
      rd_chk(4'h5, 8'he3);
      rd_chk(4'h0, 8'h22);
      $display("test receive errors done");
      wr_reg(4'h3, 8'h03);
      wr_reg(4'h1, 8'h01);
      wr_reg(4'h4, 8'h50);
      wr_reg(4'h0, 8'h5a);
      repeat (200) @(posedge ref_clk);
      #1;
      `CHK(irq, 1'b0)
      wr_reg(4'h4, 8'h58);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(irq, 1'b1)
      rd_chk(4'h0, 8'h5a);
      $display("test loopback done");
      wr_reg(4'h4, 8'h00);
      wr_reg(4'h1, 8'h00);
      wr_reg(4'h3, 8'h3b);
      wr_reg(4'h7, 8'h12);
      rx_send(8'h3b, 8'h77, 12'h000);
      rd_chk(4'h5, 8'h60);
      wr_reg(4'h4, 8'h08);
      rx_send(8'h3b, 8'h12, 12'h100);
      `CHK(irq, 1'b1)
      rx_send(8'h3b, 8'h77, 12'h000);
      rd_chk(4'h5, 8'h61);
      `CHK(irq, 1'b0)
      rd_chk(4'h0, 8'h77);
      wr_reg(4'h4, 8'h00);
      wr_reg(4'h7, 8'hff);
      rx_send(8'h3b, 8'h77, 12'h000);
      rd_chk(4'h5, 8'h61);
      rd_chk(4'h0, 8'h77);
      $display("test address match done");
      give_verdict();
   end
endmodule : tb_top
